// [rtl/ifb_regs.vh]
// Register offsets, field positions and reset values of the flag and enable bank
`ifndef IFB_REGS_VH
`define IFB_REGS_VH
`define IFB_ADDR_PRI1    4'h0
`define IFB_ADDR_PRI2    4'h4
`define IFB_ADDR_PRI3    4'h8
`define IFB_ADDR_GRP0    4'hc
`define IFB_ADDR_GRP1    5'h10
`define IFB_ADDR_CTRL    5'h14
`define IFB_RST_BYTE     8'h00
// Primary 1
`define IFB_P1_G1F       7
`define IFB_P1_G0F       6
`define IFB_P1_LVF       5
`define IFB_P1_SIF       4
`define IFB_P1_G1E       3
`define IFB_P1_G0E       2
`define IFB_P1_LVE       1
`define IFB_P1_SIE       0
// Primary 2
`define IFB_P2_C1F       7
`define IFB_P2_TIMEBASE1_REQ_FLAG      6
`define IFB_P2_TIMEBASE0_REQ_FLAG      5
`define IFB_P2_G2F       4
`define IFB_P2_C1E       3
`define IFB_P2_TIMEBASE1_IRQ_EN      2
`define IFB_P2_TIMEBASE0_IRQ_EN      1
`define IFB_P2_G2E       0
// Primary 3
`define IFB_P3_G5F       6
`define IFB_P3_G4F       5
`define IFB_P3_G3F       4
`define IFB_P3_G5E       2
`define IFB_P3_G4E       1
`define IFB_P3_G3E       0
`define IFB_P3_MASK      8'h77
// Grouped registers 0 and 1
`define IFB_G_HIF        5
`define IFB_G_LOF        4
`define IFB_G_HIE        1
`define IFB_G_LOE        0
`define IFB_G_MASK       8'h33
// Control register: global enable at bit 0
`define IFB_CTRL_GIE     0
`endif

// [rtl/ifb_flag_reg.v]
// One byte of request flags and enables with hardware set and software write
`timescale 1ns/1ns
`default_nettype none
module ifb_flag_reg #(
  parameter [7:0] MASK = 8'hff
) (
  input  wire       i_clk,
  input  wire       i_rst,
  input  wire       i_wr,
  input  wire [7:0] i_wdata,
  input  wire [7:0] i_set,
  output wire [7:0] o_q
);
  reg  [7:0] q_r;
  wire [7:0] q_nxt;
  // Hardware set wins over a software clear in the same cycle
  assign q_nxt = ((i_wr ? i_wdata : q_r) | i_set) & MASK;
  always @(posedge i_clk) begin
    if (i_rst) begin
      q_r <= 8'h00;
    end else begin
      q_r <= q_nxt;
    end
  end
  assign o_q = q_r;
endmodule // ifb_flag_reg
`default_nettype wire

// [rtl/ifb_bank.v]
// Interrupt request flag and enable bank with a classic Wishbone slave
//
// Local design decisions: the Wishbone register port and the register addresses.
`timescale 1ns/1ns
`default_nettype none
`include "ifb_regs.vh"
////////////////////////////////////////////////////////////////////////////////
// What this block does
// RULE1: Primary 1 bits 7 and 6 hold group 1 and group 0 request flags.
// RULE2: Primary 1 bits 5 and 4 hold low-voltage and serial request flags.
// RULE3: Primary 1 bits 3 and 2 enable group 1 and group 0.
// RULE4: Primary 1 bits 1 and 0 enable low-voltage and serial sources.
// RULE5: Primary 2 bit 7 is comparator 1 flag, bit 3 its enable.
// RULE6: Primary 2 bits 6 and 5 are time base 1 and 0 flags.
// RULE7: Primary 2 bits 2 and 1 enable time base 1 and 0.
// RULE8: Primary 2 bit 4 is group 2 flag, bit 0 its enable.
// RULE9: Primary 3 bits 6, 5, 4 are group 5, 4, 3 flags.
// RULE10: Primary 3 bits 2, 1, 0 enable groups 5, 4, 3.
// RULE11: Unimplemented bits always read zero.
// RULE12: Grouped 0 bits 5 and 4 are EEPROM and converter flags.
// RULE13: Grouped 0 bits 1 and 0 enable EEPROM and converter.
// RULE14: Grouped 1 bits 5 and 4 are timer compare A and P flags.
// RULE15: Grouped 1 bits 1 and 0 enable timer compare A and P.
// RULE16: Hardware sets flags on source events; software writes enables.
// RULE17: Core request only when flag, its enable and global enable all set.
// RULE18: Group flag sets when an enabled flag in its grouped register is set.
module ifb_bank (
  input  wire        I_REF_CLK,
  input  wire        I_RST,
  input  wire        I_WB_CYC,
  input  wire        I_WB_STB,
  input  wire        I_WB_WE,
  input  wire [4:0]  I_WB_ADR,
  input  wire [3:0]  I_WB_SEL,
  input  wire [31:0] I_WB_DAT,
  output reg  [31:0] O_WB_DAT,
  output reg         O_WB_ACK,
  input  wire        i_low_volt_evt,
  input  wire        i_serial_evt,
  input  wire        i_line_cmp1_evt,
  input  wire        i_timebase0_evt,
  input  wire        i_timebase1_evt,
  input  wire        i_eeprom_evt,
  input  wire        i_conv_evt,
  input  wire        i_ptimer0_cmpa_evt,
  input  wire        i_ptimer0_cmpp_evt,
  input  wire [2:0]  i_group_evt,
  output reg         O_CORE_IRQ
);
  ////////////////////////////////////////////////////////////////////////////////
  // Bus decode
  wire       req      = I_WB_CYC & I_WB_STB & ~O_WB_ACK;
  wire       wr_lane0 = req & I_WB_WE & I_WB_SEL[0];
  wire [7:0] wd       = I_WB_DAT[7:0];
  wire [7:0] pri1_q;
  wire [7:0] pri2_q;
  wire [7:0] pri3_q;
  wire [7:0] grp0_q;
  wire [7:0] grp1_q;
  reg        global_irq_en_r;
  wire       wr_pri1 = wr_lane0 & (I_WB_ADR == {1'b0, `IFB_ADDR_PRI1});
  wire       wr_pri2 = wr_lane0 & (I_WB_ADR == {1'b0, `IFB_ADDR_PRI2});
  wire       wr_pri3 = wr_lane0 & (I_WB_ADR == {1'b0, `IFB_ADDR_PRI3});
  wire       wr_grp0 = wr_lane0 & (I_WB_ADR == {1'b0, `IFB_ADDR_GRP0});
  wire       wr_grp1 = wr_lane0 & (I_WB_ADR == `IFB_ADDR_GRP1);
  wire       wr_ctrl = wr_lane0 & (I_WB_ADR == `IFB_ADDR_CTRL);
  ////////////////////////////////////////////////////////////////////////////////
  // Grouped sources and their group flags
  wire grp0_any = (grp0_q[`IFB_G_HIF] & grp0_q[`IFB_G_HIE]) |
                  (grp0_q[`IFB_G_LOF] & grp0_q[`IFB_G_LOE]); // RULE18
  wire grp1_any = (grp1_q[`IFB_G_HIF] & grp1_q[`IFB_G_HIE]) |
                  (grp1_q[`IFB_G_LOF] & grp1_q[`IFB_G_LOE]); // RULE18
  wire [7:0] grp0_set = {2'b00, i_eeprom_evt, i_conv_evt, 4'h0};             // RULE12 RULE16
  wire [7:0] grp1_set = {2'b00, i_ptimer0_cmpa_evt, i_ptimer0_cmpp_evt, 4'h0}; // RULE14 RULE16
  wire [7:0] pri1_set = {grp1_any, grp0_any, i_low_volt_evt, i_serial_evt, 4'h0}; // RULE1 RULE2 RULE16
  wire [7:0] pri2_set = {i_line_cmp1_evt, i_timebase1_evt, i_timebase0_evt, i_group_evt[0], 4'h0}; // RULE5 RULE6 RULE8
  // Group 3 has no hardware source here, software alone sets its flag
  wire [7:0] pri3_set = {1'b0, i_group_evt[2], i_group_evt[1], 1'b0, 4'h0};  // RULE9
  ////////////////////////////////////////////////////////////////////////////////
  // Flag registers; enables are plain software bits
  ifb_flag_reg #(.MASK(8'hff)) u_pri1 (
    .i_clk(I_REF_CLK), .i_rst(I_RST), .i_wr(wr_pri1), .i_wdata(wd), .i_set(pri1_set), .o_q(pri1_q)); // RULE3 RULE4
  ifb_flag_reg #(.MASK(8'hff)) u_pri2 (
    .i_clk(I_REF_CLK), .i_rst(I_RST), .i_wr(wr_pri2), .i_wdata(wd), .i_set(pri2_set), .o_q(pri2_q)); // RULE7
  ifb_flag_reg #(.MASK(`IFB_P3_MASK)) u_pri3 (
    .i_clk(I_REF_CLK), .i_rst(I_RST), .i_wr(wr_pri3), .i_wdata(wd), .i_set(pri3_set), .o_q(pri3_q)); // RULE10 RULE11
  ifb_flag_reg #(.MASK(`IFB_G_MASK)) u_grp0 (
    .i_clk(I_REF_CLK), .i_rst(I_RST), .i_wr(wr_grp0), .i_wdata(wd), .i_set(grp0_set), .o_q(grp0_q)); // RULE13 RULE11
  ifb_flag_reg #(.MASK(`IFB_G_MASK)) u_grp1 (
    .i_clk(I_REF_CLK), .i_rst(I_RST), .i_wr(wr_grp1), .i_wdata(wd), .i_set(grp1_set), .o_q(grp1_q)); // RULE15 RULE11
  ////////////////////////////////////////////////////////////////////////////////
  // Core request
  wire group3_fire = pri3_q[`IFB_P3_G3F] & pri3_q[`IFB_P3_G3E];
  wire [5:0] pending = {
    pri3_q[`IFB_P3_G5F] & pri3_q[`IFB_P3_G5E],
    pri3_q[`IFB_P3_G4F] & pri3_q[`IFB_P3_G4E],
    group3_fire,
    |(pri2_q[7:4] & pri2_q[3:0]),
    |(pri1_q[7:4] & pri1_q[3:0]),
    1'b0};
  always @(posedge I_REF_CLK) begin
    if (I_RST) begin
      global_irq_en_r <= 1'b0;
      O_CORE_IRQ      <= 1'b0;
      O_WB_ACK        <= 1'b0;
      O_WB_DAT        <= 32'h0000_0000;
    end else begin
      if (wr_ctrl) begin
        global_irq_en_r <= wd[`IFB_CTRL_GIE];
      end
      O_CORE_IRQ <= global_irq_en_r & (|pending); // RULE17
      O_WB_ACK   <= req;
      if (req & ~I_WB_WE) begin
        case (I_WB_ADR)
          {1'b0, `IFB_ADDR_PRI1}: O_WB_DAT <= {24'h000000, pri1_q};
          {1'b0, `IFB_ADDR_PRI2}: O_WB_DAT <= {24'h000000, pri2_q};
          {1'b0, `IFB_ADDR_PRI3}: O_WB_DAT <= {24'h000000, pri3_q};
          {1'b0, `IFB_ADDR_GRP0}: O_WB_DAT <= {24'h000000, grp0_q};
          `IFB_ADDR_GRP1:         O_WB_DAT <= {24'h000000, grp1_q};
          `IFB_ADDR_CTRL:         O_WB_DAT <= {31'h00000000, global_irq_en_r};
          default:                O_WB_DAT <= 32'h0000_0000; // RULE11
        endcase
      end
    end
  end
endmodule // ifb_bank
`default_nettype wire

// [sim/ifb_bank_checker.sv]
// Bus timing, spare bit and request output checks for the flag bank
`timescale 1ns/1ns
`default_nettype none
module ifb_bank_checker (
  input wire logic        I_REF_CLK,
  input wire logic        I_RST,
  input wire logic        I_WB_CYC,
  input wire logic        I_WB_STB,
  input wire logic        I_WB_WE,
  input wire logic        O_WB_ACK,
  input wire logic        O_CORE_IRQ,
  input wire logic [4:0]  I_WB_ADR,
  input wire logic [31:0] O_WB_DAT
);
  default clocking @(posedge I_REF_CLK); endclocking
  default disable iff (I_RST);
  wire rd = I_WB_CYC && I_WB_STB && !I_WB_WE && !O_WB_ACK;
  wire wr = I_WB_CYC && I_WB_STB && I_WB_WE;
  ////////////////////////////////////////
  a_ack_follows_req: assert property (I_WB_CYC && I_WB_STB && !O_WB_ACK |=> O_WB_ACK) else $error("ack missing");
  a_ack_single_pulse: assert property (O_WB_ACK |=> !O_WB_ACK) else $error("ack too long");
  a_no_stray_ack: assert property (!(I_WB_CYC && I_WB_STB) |=> !O_WB_ACK) else $error("ack without request");
  a_unmapped_zero: assert property (rd && I_WB_ADR >= 5'h18 |=> O_WB_DAT == 32'h0) else $error("unmapped nonzero");
  a_pri3_spare_zero: assert property (rd && I_WB_ADR == 5'h08 |=> (O_WB_DAT & ~32'h77) == 32'h0) else $error("spare set");
  a_grp_spare_zero: assert property (rd && I_WB_ADR inside {5'h0c, 5'h10} |=> (O_WB_DAT & ~32'h33) == 32'h0) else $error("spare set");
  a_dat_holds: assert property (!rd |=> $stable(O_WB_DAT)) else $error("read data moved");
  // Flags clear only by software, so a drop needs a write or reset
  a_irq_fall_cause: assert property ($fell(O_CORE_IRQ) |-> $past(wr, 2) || $past(I_RST)) else $error("irq dropped");
endmodule // ifb_bank_checker
bind ifb_bank ifb_bank_checker u_chk (
  .I_REF_CLK(I_REF_CLK),
  .I_RST(I_RST),
  .I_WB_CYC(I_WB_CYC),
  .I_WB_STB(I_WB_STB),
  .I_WB_WE(I_WB_WE),
  .O_WB_ACK(O_WB_ACK),
  .O_CORE_IRQ(O_CORE_IRQ),
  .I_WB_ADR(I_WB_ADR),
  .O_WB_DAT(O_WB_DAT)
);
`default_nettype wire

// [sim/ifb_src_model.sv]
// Peripheral event sources: a fired pulse is held for a chosen length
`timescale 1ns/1ns
`default_nettype none
module ifb_src_model (
  input  wire logic        clk,
  input  wire logic [11:0] fire,
  input  wire logic [2:0]  len,
  output logic      [11:0] o_evt
);
  logic [11:0] held;
  logic [2:0]  left = 3'h0;
  always @(posedge clk) begin
    if (fire != 12'h0) begin
      held <= fire;
      left <= len;
    end else if (left != 3'h0) left <= left - 3'h1;
  end
  assign o_evt = (left != 3'h0) ? held : 12'h0;
endmodule // ifb_src_model
`default_nettype wire

// [sim/test_ifb_bank.sv]
// Self-checking bench for the flag and enable bank
`timescale 1ns/1ns
`default_nettype none
module test_ifb_bank;
  logic clk = 0, rst = 1, cyc = 0, stb = 0, we = 0, ack, irq;
  logic [4:0] adr = 0, a;
  logic [3:0] sel = 0;
  logic [31:0] wd = 0, rdat, got;
  logic [11:0] fire = 0, evt;
  logic [2:0] len = 1, b;
  integer fails = 0, samples_checked = 0, seed = 50773, i, j;
  logic [7:0] d [5];
  logic [7:0] msk [5] = '{8'hff, 8'hff, 8'h77, 8'h33, 8'h33};
  // Source table: word index and flag bit
  logic [5:0] tbl [12] = '{6'h05, 6'h04, 6'h0f, 6'h0d, 6'h0e, 6'h1d, 6'h1c, 6'h25, 6'h24, 6'h0c, 6'h15, 6'h16};
  always #50 clk = ~clk;
  ifb_bank DUT (.I_REF_CLK(clk), .I_RST(rst), .I_WB_CYC(cyc), .I_WB_STB(stb), .I_WB_WE(we), .I_WB_ADR(adr),
    .I_WB_SEL(sel), .I_WB_DAT(wd), .O_WB_DAT(rdat), .O_WB_ACK(ack), .i_low_volt_evt(evt[0]),
    .i_serial_evt(evt[1]), .i_line_cmp1_evt(evt[2]), .i_timebase0_evt(evt[3]), .i_timebase1_evt(evt[4]),
    .i_eeprom_evt(evt[5]), .i_conv_evt(evt[6]), .i_ptimer0_cmpa_evt(evt[7]), .i_ptimer0_cmpp_evt(evt[8]),
    .i_group_evt(evt[11:9]), .O_CORE_IRQ(irq));
  ifb_src_model SRC (.clk(clk), .fire(fire), .len(len), .o_evt(evt));
  ////////////////////////////////////////
  function automatic logic grp(input logic [7:0] v);
    return (v[5] & v[1]) | (v[4] & v[0]);
  endfunction
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic bus(input logic w, input logic [4:0] ad, input logic [7:0] v, input logic s);
    integer n;
    n = 0;
    @(posedge clk);
    {cyc, stb, we, adr, sel, wd} <= {2'b11, w, ad, 3'b000, s, 24'h0, v};
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    got = rdat;
    {cyc, stb, we} <= 3'b000;
    if (n >= 20) chk("ack", 1, 0);
  endtask
  task automatic rd(input logic [4:0] ad, input logic [7:0] e, input string nm);
    bus(1'b0, ad, 8'h00, 1'b1);
    chk(nm, {24'h0, e}, got);
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    give_verdict;
  end
  initial begin
    repeat (5) @(posedge clk);
    rst <= 0;
    for (i = 0; i < 7; i++) rd(5'(i * 4), 8'h00, "reset value");
    $display("test reset done");
    for (i = 0; i < 5; i++) begin
      d[i] = 8'($random(seed));
      bus(1'b1, 5'(i * 4), d[i], 1'b1);
      rd(5'(i * 4), d[i] & msk[i], "readback");
    end
    bus(1'b1, 5'h00, ~d[0], 1'b0);
    rd(5'h00, d[0] | {grp(d[4]), grp(d[3]), 6'h0}, "group set");
    chk("irq no global", 0, irq);
    bus(1'b1, 5'h18, 8'hff, 1'b1);
    rd(5'h18, 8'h00, "unmapped");
    $display("test registers done");
    bus(1'b1, 5'h14, 8'h01, 1'b1);
    for (i = 0; i < 12; i++) begin
      // Grouped first so no group flag is set again behind the clear
      for (j = 4; j >= 0; j--) bus(1'b1, 5'(j * 4), 8'h00, 1'b1);
      a = {tbl[i][5:3], 2'b00};
      b = tbl[i][2:0];
      len <= 3'($random(seed)) | 3'h1;
      fire <= 12'h1 << i;
      @(posedge clk);
      fire <= 12'h0;
      repeat (10) @(posedge clk);
      rd(a, 8'h1 << b, "event flag");
      chk("irq masked", 0, irq);
      bus(1'b1, a, (8'h1 << b) | (8'h1 << (b - 3'd4)), 1'b1);
      if (a > 5'h08) bus(1'b1, 5'h00, 8'h0c, 1'b1);
      repeat (4) @(posedge clk);
      chk("irq raised", 1, irq);
      bus(1'b1, 5'h14, 8'h00, 1'b1);
      repeat (4) @(posedge clk);
      chk("irq gated", 0, irq);
      bus(1'b1, 5'h14, 8'h01, 1'b1);
    end
    // Group 3 has no event input, so its request path is driven by software
    for (j = 4; j >= 0; j--) bus(1'b1, 5'(j * 4), 8'h00, 1'b1);
    bus(1'b1, 5'h08, 8'h11, 1'b1);
    repeat (4) @(posedge clk);
    chk("irq group3", 1, irq);
    $display("test events done");
    give_verdict;
  end
endmodule // test_ifb_bank
`default_nettype wire
